// *** include/tpp_consts.vh ***
`ifndef TPP_CONSTS_VH
`define TPP_CONSTS_VH

`define TPP_ADDR_W        12
`define TPP_IDX_SLV_DATA  10'h008
`define TPP_IDX_PORT_DATA 10'h009
`define TPP_IDX_BIT_OP    10'h00A
`define TPP_IDX_DIR_STAT  10'h089
`define TPP_IDX_ANALOG    10'h09F

`define TPP_SEL_NONE      3'h0
`define TPP_SEL_SLV       3'h1
`define TPP_SEL_PORT      3'h2
`define TPP_SEL_BITOP     3'h3
`define TPP_SEL_DIR       3'h4
`define TPP_SEL_ANA       3'h5

`define TPP_BIT_IBF       7
`define TPP_BIT_OBF       6
`define TPP_BIT_INBOUND_OVERRUN_FLAG      5
`define TPP_BIT_SPS       4
`define TPP_BIT_OP_SET    7

`define TPP_DIR_RST       3'h7
`define TPP_ANA_RST       3'h0
`define TPP_LATCH_RST     3'h0
`define TPP_BYTE_RST      8'h00
`define TPP_DIGITAL_CFG   2'h3

`define TPP_RESP_OKAY     2'h0
`define TPP_RESP_SLVERR   2'h2

`endif

// *** logic/tpp_axil_slave.v ***
`timescale 1ns/100ps
`default_nettype none
`include "tpp_consts.vh"

module tpp_axil_slave (
	input  wire                   sys_clk,  // system clock
	input  wire                   rst_b,    // synchronous reset, active low
	input  wire [`TPP_ADDR_W-1:0] awaddr,   // write address
	input  wire                   awvalid,  // write address valid
	output reg                    awready,  // write address ready
	input  wire [31:0]            wdata,    // write data
	input  wire [3:0]             wstrb,    // write byte strobes
	input  wire                   wvalid,   // write data valid
	output reg                    wready,   // write data ready
	output reg  [1:0]             bresp,    // write response
	output reg                    bvalid,   // write response valid
	input  wire                   bready,   // write response ready
	input  wire [`TPP_ADDR_W-1:0] araddr,   // read address
	input  wire                   arvalid,  // read address valid
	output reg                    arready,  // read address ready
	output reg  [31:0]            rdata,    // read data
	output reg  [1:0]             rresp,    // read response
	output reg                    rvalid,   // read data valid
	input  wire                   rready,   // read data ready
	output wire                   wr_go,    // register write strobe
	output reg  [`TPP_ADDR_W-1:0] wr_addr,  // held write address
	output reg  [31:0]            wr_data,  // held write data
	output reg  [3:0]             wr_strb,  // held byte strobes
	input  wire                   wr_err,   // write address unmapped
	output wire                   rd_go,    // register read strobe
	output reg  [`TPP_ADDR_W-1:0] rd_addr,  // held read address
	input  wire [31:0]            rd_data,  // read data from registers
	input  wire                   rd_err    // read address unmapped
);

	reg aw_have_reg;
	reg w_have_reg;
	reg ar_have_reg;

	assign wr_go = aw_have_reg & w_have_reg & ~bvalid;
	assign rd_go = ar_have_reg & ~rvalid;

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			awready     <= 1'b1;
			wready      <= 1'b1;
			bvalid      <= 1'b0;
			bresp       <= `TPP_RESP_OKAY;
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			wr_addr     <= {`TPP_ADDR_W{1'b0}};
			wr_data     <= 32'h00000000;
			wr_strb     <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_have_reg <= 1'b1;
				awready     <= 1'b0;
				wr_addr     <= awaddr;
			end
			if (wvalid && wready) begin
				w_have_reg <= 1'b1;
				wready     <= 1'b0;
				wr_data    <= wdata;
				wr_strb    <= wstrb;
			end
			if (wr_go) begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				bvalid      <= 1'b1;
				bresp       <= wr_err ? `TPP_RESP_SLVERR : `TPP_RESP_OKAY;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			arready     <= 1'b1;
			rvalid      <= 1'b0;
			rresp       <= `TPP_RESP_OKAY;
			rdata       <= 32'h00000000;
			ar_have_reg <= 1'b0;
			rd_addr     <= {`TPP_ADDR_W{1'b0}};
		end else begin
			if (arvalid && arready) begin
				ar_have_reg <= 1'b1;
				arready     <= 1'b0;
				rd_addr     <= araddr;
			end
			if (rd_go) begin
				ar_have_reg <= 1'b0;
				rvalid      <= 1'b1;
				rdata       <= rd_data;
				rresp       <= rd_err ? `TPP_RESP_SLVERR : `TPP_RESP_OKAY;
			end
			if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule // tpp_axil_slave

`default_nettype wire

// *** logic/tpp_port.v ***
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "tpp_consts.vh"

module tpp_port (
	input  wire                   sys_clk,         // system clock, 100 MHz
	input  wire                   rst_b,           // synchronous reset, active low
	input  wire [`TPP_ADDR_W-1:0] s_axi_awaddr,    // AXI write address
	input  wire                   s_axi_awvalid,   // AXI write address valid
	output wire                   s_axi_awready,   // AXI write address ready
	input  wire [31:0]            s_axi_wdata,     // AXI write data
	input  wire [3:0]             s_axi_wstrb,     // AXI write strobes
	input  wire                   s_axi_wvalid,    // AXI write data valid
	output wire                   s_axi_wready,    // AXI write data ready
	output wire [1:0]             s_axi_bresp,     // AXI write response
	output wire                   s_axi_bvalid,    // AXI write response valid
	input  wire                   s_axi_bready,    // AXI write response ready
	input  wire [`TPP_ADDR_W-1:0] s_axi_araddr,    // AXI read address
	input  wire                   s_axi_arvalid,   // AXI read address valid
	output wire                   s_axi_arready,   // AXI read address ready
	output wire [31:0]            s_axi_rdata,     // AXI read data
	output wire [1:0]             s_axi_rresp,     // AXI read response
	output wire                   s_axi_rvalid,    // AXI read data valid
	input  wire                   s_axi_rready,    // AXI read data ready
	input  wire [2:0]             aux_pin_in,      // pin levels; 0 read, 1 write, 2 select
	output reg  [2:0]             aux_pin_out,     // output latch
	output reg  [2:0]             aux_pin_oe,      // pin drive enables
	output reg  [2:0]             aux_analog_sel,  // pins routed to the analog mux
	input  wire [7:0]             slv_data_in,     // external data bus levels
	output reg  [7:0]             slv_data_out,    // outbound byte to the bus
	output reg                    slv_data_oe      // bus drive enable
);

	// A mask bit is 1 for every pin that the configuration makes analog.
	function [2:0] tpp_analog_mask;
		input [2:0] cfg;
		begin
			if (cfg[2:1] == `TPP_DIGITAL_CFG)
				tpp_analog_mask = 3'h0;
			else
				tpp_analog_mask = 3'h7;
		end
	endfunction

	function [2:0] tpp_decode;
		input [`TPP_ADDR_W-1:0] addr;
		begin
			tpp_decode = `TPP_SEL_NONE;
			if (addr[1:0] == 2'h0) begin
				case (addr[`TPP_ADDR_W-1:2])
					`TPP_IDX_SLV_DATA:  tpp_decode = `TPP_SEL_SLV;
					`TPP_IDX_PORT_DATA: tpp_decode = `TPP_SEL_PORT;
					`TPP_IDX_BIT_OP:    tpp_decode = `TPP_SEL_BITOP;
					`TPP_IDX_DIR_STAT:  tpp_decode = `TPP_SEL_DIR;
					`TPP_IDX_ANALOG:    tpp_decode = `TPP_SEL_ANA;
					default:            tpp_decode = `TPP_SEL_NONE;
				endcase
			end
		end
	endfunction

	// One-hot select of a single pin; index 3 selects none, so the bit
	// operation then rewrites the pin levels unchanged.
	function [2:0] tpp_pin_mask;
		input [1:0] idx;
		begin
			case (idx)
				2'h0:    tpp_pin_mask = 3'h1;
				2'h1:    tpp_pin_mask = 3'h2;
				2'h2:    tpp_pin_mask = 3'h4;
				default: tpp_pin_mask = 3'h0;
			endcase
		end
	endfunction

	reg  [2:0]  dir_reg;
	reg         sps_reg;
	reg         ibf_reg;
	reg         obf_reg;
	reg         inbound_overrun_flag_reg;
	reg  [2:0]  ana_reg;
	reg  [7:0]  in_latch_reg;
	reg  [7:0]  wcap_reg;
	reg         wr_act_q_reg;
	reg         rd_act_q_reg;

	wire        wr_go;
	wire [`TPP_ADDR_W-1:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0]  wr_strb;
	wire        rd_go;
	wire [`TPP_ADDR_W-1:0] rd_addr;
	wire [10:0] sync_level;

	reg  [31:0] rd_data;
	reg         rd_err;
	reg         wr_err;
	reg  [2:0]  bit_result;
	reg  [2:0]  bit_mask;

	wire [2:0]  wr_sel;
	wire [2:0]  rd_sel;
	wire        wr_lane;
	wire [2:0]  pins;
	wire [7:0]  bus_level;
	wire [2:0]  analog_now;
	wire [2:0]  pin_read;
	wire        sel_n;
	wire        rd_n;
	wire        wr_n;
	wire        wr_act;
	wire        rd_act;
	wire        wr_done;
	wire        rd_start;
	wire        slv_read;
	wire        slv_write;
	wire        in_accept;
	wire        in_overrun;
	wire        wr_dir_en;
	wire        wr_ana_en;
	wire        wr_port_en;
	wire        wr_bit_en;
	wire [7:0]  dir_stat_word;

	tpp_axil_slave u_bus (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.wr_go   (wr_go),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_err  (wr_err),
		.rd_go   (rd_go),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	// Pins and the data bus come from outside the clock domain.
	tpp_sync3 #(
		.WIDTH (11)
	) u_sync (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.async_in  ({slv_data_in, aux_pin_in}),
		.level_out (sync_level)
	);

	assign pins      = sync_level[2:0];
	assign bus_level = sync_level[10:3];
	assign wr_sel    = tpp_decode(wr_addr);
	assign rd_sel    = tpp_decode(rd_addr);
	assign wr_lane   = wr_go & wr_strb[0];

	// Only byte lane 0 carries register bits; a write without it is answered
	// but changes nothing.
	assign wr_dir_en  = wr_lane & (wr_sel == `TPP_SEL_DIR);
	assign wr_ana_en  = wr_lane & (wr_sel == `TPP_SEL_ANA);
	assign wr_port_en = wr_lane & (wr_sel == `TPP_SEL_PORT);
	assign wr_bit_en  = wr_lane & (wr_sel == `TPP_SEL_BITOP);

	assign analog_now = tpp_analog_mask(ana_reg);
	assign pin_read   = pins & ~analog_now;

	// Bit 3 is unimplemented and always reads zero.
	assign dir_stat_word = {ibf_reg, obf_reg, inbound_overrun_flag_reg, sps_reg, 1'b0, dir_reg};

	// Strobes only count while the device is selected and in slave mode.
	assign sel_n  = pins[2];
	assign rd_n   = pins[0];
	assign wr_n   = pins[1];
	assign wr_act = sps_reg & ~sel_n & ~wr_n;
	assign rd_act = sps_reg & ~sel_n & ~rd_n;

	// A write completes when either strobe rises; leaving slave mode mid
	// strobe drops the byte rather than inventing a completion.
	assign wr_done  = sps_reg & wr_act_q_reg & ~wr_act;
	assign rd_start = rd_act & ~rd_act_q_reg;

	assign slv_read  = rd_go & (rd_sel == `TPP_SEL_SLV);
	assign slv_write = wr_lane & (wr_sel == `TPP_SEL_SLV);

	// A byte that lands while software is reading the old one is taken,
	// so the fresh arrival wins over the clear.
	assign in_accept  = wr_done & (~ibf_reg | slv_read);
	assign in_overrun = wr_done & ibf_reg & ~slv_read;

	always @* begin
		wr_err = (wr_sel == `TPP_SEL_NONE);
		rd_err = (rd_sel == `TPP_SEL_NONE);
		rd_data = 32'h00000000;
		case (rd_sel)
			`TPP_SEL_SLV:  rd_data[7:0] = in_latch_reg;
			`TPP_SEL_PORT: rd_data[2:0] = pin_read;
			`TPP_SEL_DIR:  rd_data[7:0] = dir_stat_word;
			`TPP_SEL_ANA:  rd_data[2:0] = ana_reg;
			default:       rd_data = 32'h00000000;
		endcase
	end

	// Bit set and clear start from the pin levels, so a digital input pin's level
	// lands in its latch bit; switching it to output later shows that level.
	always @* begin
		bit_mask   = tpp_pin_mask(wr_data[1:0]);
		bit_result = pin_read & ~bit_mask;
		if (wr_data[`TPP_BIT_OP_SET])
			bit_result = bit_result | bit_mask;
	end

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			dir_reg  <= `TPP_DIR_RST;
			sps_reg  <= 1'b0;
			inbound_overrun_flag_reg <= 1'b0;
			ana_reg  <= `TPP_ANA_RST;
		end else begin
			if (wr_dir_en) begin
				dir_reg <= wr_data[2:0];
				sps_reg <= wr_data[`TPP_BIT_SPS];
			end
			// Software may write the overrun bit either way, but an overrun in
			// the same cycle wins so that the event is never lost.
			if (in_overrun)
				inbound_overrun_flag_reg <= 1'b1;
			else if (wr_dir_en)
				inbound_overrun_flag_reg <= wr_data[`TPP_BIT_INBOUND_OVERRUN_FLAG];
			if (wr_ana_en)
				ana_reg <= wr_data[2:0];
		end
	end

	// The latch keeps its value while a pin is an input, so turning the pin
	// into an output later drives whatever was last written or rewritten.
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			aux_pin_out <= `TPP_LATCH_RST;
		end else if (wr_port_en) begin
			aux_pin_out <= wr_data[2:0];
		end else if (wr_bit_en) begin
			aux_pin_out <= bit_result;
		end
	end

	// Inbound side: the bus byte is sampled every cycle of an active write
	// and the last sample is kept when the strobe ends.
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			ibf_reg      <= 1'b0;
			in_latch_reg <= `TPP_BYTE_RST;
			wcap_reg     <= `TPP_BYTE_RST;
			wr_act_q_reg <= 1'b0;
		end else begin
			wr_act_q_reg <= wr_act;
			if (wr_act)
				wcap_reg <= bus_level;
			if (in_accept)
				in_latch_reg <= wcap_reg;
			if (!sps_reg)
				ibf_reg <= 1'b0;
			else if (in_accept)
				ibf_reg <= 1'b1;
			else if (slv_read)
				ibf_reg <= 1'b0;
		end
	end

	// Outbound side: a firmware write in the same cycle as a read start
	// keeps the flag set, since the new byte has not been read yet.
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			obf_reg      <= 1'b0;
			slv_data_out <= `TPP_BYTE_RST;
			rd_act_q_reg <= 1'b0;
		end else begin
			rd_act_q_reg <= rd_act;
			if (slv_write)
				slv_data_out <= wr_data[7:0];
			if (!sps_reg)
				obf_reg <= 1'b0;
			else if (slv_write)
				obf_reg <= 1'b1;
			else if (rd_start)
				obf_reg <= 1'b0;
		end
	end

	// Drivers follow the direction bits even for analog pins, which is why
	// software must leave analog pins set as inputs.
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			aux_pin_oe     <= 3'h0;
			aux_analog_sel <= 3'h7;
			slv_data_oe    <= 1'b0;
		end else begin
			aux_pin_oe     <= ~dir_reg;
			aux_analog_sel <= analog_now;
			slv_data_oe    <= rd_act;
		end
	end

endmodule // tpp_port

`default_nettype wire

// *** logic/tpp_sync3.v ***
`timescale 1ns/100ps
`default_nettype none

module tpp_sync3 #(
	parameter WIDTH = 11
) (
	input  wire             sys_clk,   // system clock
	input  wire             rst_b,     // synchronous reset, active low
	input  wire [WIDTH-1:0] async_in,  // raw pin levels
	output reg  [WIDTH-1:0] level_out  // filtered levels
);

	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;
	reg [WIDTH-1:0] stage3_reg;
	wire [WIDTH-1:0] agree;

	// A bit only moves once the second and third stages agree, so a
	// metastable settle in the second stage never reaches the output.
	assign agree = ~(stage2_reg ^ stage3_reg);

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			stage1_reg <= {WIDTH{1'b1}};
			stage2_reg <= {WIDTH{1'b1}};
			stage3_reg <= {WIDTH{1'b1}};
			level_out  <= {WIDTH{1'b1}};
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			level_out  <= (level_out & ~agree) | (stage3_reg & agree);
		end
	end

endmodule // tpp_sync3

`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [11:0] a_slv = 12'h020, a_port = 12'h024, a_bit = 12'h028;
	localparam logic [11:0] a_dir = 12'h224, a_ana = 12'h27C;
	logic        sys_clk = 1'b0, rst_b = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rd_v, lfsr = 32'h6603;
	logic        awready, wready, bvalid, arready, rvalid, slv_data_oe;
	logic [1:0]  bresp, rresp;
	logic [2:0]  pin_lvl, aux_pin_out, aux_pin_oe, aux_analog_sel, dir, lat, lvl, pins;
	logic [7:0]  bus_lvl, slv_data_out, b;
	logic [7:0]  m_in[$];
	int          miscompares = 0, checks_done = 0, m_ts = 7, i;
	tpp_port dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.aux_pin_in(pin_lvl), .aux_pin_out(aux_pin_out), .aux_pin_oe(aux_pin_oe),
		.aux_analog_sel(aux_analog_sel), .slv_data_in(bus_lvl), .slv_data_out(slv_data_out),
		.slv_data_oe(slv_data_oe));
	tpp_ext_cpu cpu_u (.sys_clk(sys_clk), .aux_pin_out(aux_pin_out), .aux_pin_oe(aux_pin_oe),
		.slv_data_out(slv_data_out), .slv_data_oe(slv_data_oe), .pin_lvl(pin_lvl),
		.bus_lvl(bus_lvl));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (miscompares == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic axi(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r, output logic [31:0] q);
		@(posedge sys_clk);
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= w;
		wvalid <= w;
		bready <= w;
		arvalid <= !w;
		rready <= !w;
		forever begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
			if (bvalid || rvalid) break;
		end
		bready <= 1'b0;
		rready <= 1'b0;
		q = rdata;
		chk({30'h0, w ? bresp : rresp}, {30'h0, r});
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		axi(1'b1, a, d, 2'h0, rd_v);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		axi(1'b0, a, 32'h0, 2'h0, rd_v);
		chk(rd_v, e);
	endtask
	task automatic wdir(input logic [7:0] v);
		wr(a_dir, {24'h0, v});
		m_ts = (m_ts & 8'hC0) | (v & 8'h37);
		if (!v[4]) m_ts = m_ts & 8'h3F;
	endtask
	initial begin
		#200000;
		miscompares++;
		finish_test();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		rdc(a_dir, 32'h07);
		rdc(a_ana, 32'h00);
		rdc(a_port, 32'h00);
		axi(1'b0, 12'h300, 32'h0, 2'h2, rd_v);
		chk(rd_v, 32'h0);
		axi(1'b1, 12'h300, 32'h5, 2'h2, rd_v);
		wr(a_ana, 32'h06);
		// Strobe-like levels land here too, while slave-port mode is off.
		for (i = 0; i < 10; i++) begin
			lfsr = lfsr_next(lfsr);
			{lvl, lat, dir} = lfsr[8:0];
			cpu_u.ext_lvl <= lvl;
			wdir({5'h0, dir});
			wr(a_port, {29'h0, lat});
			repeat (6) @(posedge sys_clk);
			chk({29'h0, aux_pin_oe}, {29'h0, ~dir});
			chk({29'h0, aux_pin_out}, {29'h0, lat});
			pins = (dir & lvl) | (~dir & lat);
			rdc(a_port, {29'h0, pins});
			wr(a_bit, {24'h0, lfsr[11], 5'h0, lfsr[10:9]});
			if (lfsr[10:9] != 2'h3) pins[lfsr[10:9]] = lfsr[11];
			chk({29'h0, aux_pin_out}, {29'h0, pins});
		end
		wdir(8'hEF);
		rdc(a_dir, m_ts);
		wdir(8'h00);
		wr(a_ana, 32'h00);
		repeat (6) @(posedge sys_clk);
		chk({29'h0, aux_pin_oe}, 32'h7);
		chk({29'h0, aux_analog_sel}, 32'h7);
		rdc(a_port, 32'h0);
		// Strobes idle, pins input and digital, and settled before slave mode.
		cpu_u.ext_lvl <= 3'h7;
		wdir(8'h07);
		wr(a_ana, 32'h06);
		repeat (6) @(posedge sys_clk);
		wdir(8'h17);
		rdc(a_dir, m_ts);
		wr(a_slv, 32'hA5);
		m_ts = m_ts | 8'h40;
		rdc(a_dir, m_ts);
		cpu_u.ext_read(b);
		chk({24'h0, b}, 32'hA5);
		m_ts = m_ts & 8'hBF;
		rdc(a_dir, m_ts);
		for (i = 0; i < 3; i++) begin
			lfsr = lfsr_next(lfsr);
			cpu_u.ext_write(lfsr[7:0], (i == 2) ? 3'h5 : 3'h1);
			if (i < 2 && m_ts[7]) m_ts = m_ts | 8'h20;
			if (i < 2 && !m_ts[7]) m_in.push_back(lfsr[7:0]);
			if (i < 2) m_ts = m_ts | 8'h80;
			rdc(a_dir, m_ts);
		end
		rdc(a_slv, {24'h0, m_in.pop_front()});
		m_ts = m_ts & 8'h7F;
		rdc(a_dir, m_ts);
		wr(a_slv, 32'h3C);
		wdir(8'h27);
		rdc(a_dir, m_ts);
		cpu_u.ext_write(8'h99, 3'h1);
		wdir(8'h17);
		cpu_u.ext_read(b);
		chk({24'h0, b}, 32'h3C);
		rdc(a_dir, m_ts);
		// A second reset mid-run must restore the state as on power-up.
		rst_b <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		rdc(a_dir, 32'h07);
		chk({29'h0, aux_analog_sel}, 32'h7);
		finish_test();
	end
endmodule // testbench
`default_nettype wire

// *** test/tpp_ext_cpu.sv ***
`timescale 1ns/100ps
`default_nettype none
module tpp_ext_cpu (
	input  wire logic       sys_clk,      // clock
	input  wire logic [2:0] aux_pin_out,  // port latch
	input  wire logic [2:0] aux_pin_oe,   // port drive enables
	input  wire logic [7:0] slv_data_out, // outbound byte
	input  wire logic       slv_data_oe,  // bus drive enable
	output wire logic [2:0] pin_lvl,      // resolved pin levels
	output wire logic [7:0] bus_lvl       // resolved bus levels
);
	logic [2:0] ext_lvl = 3'h7;
	logic [7:0] ext_byte = 8'h00;
	logic       ext_drv = 1'b0;
	logic [7:0] last_bus = 8'h00;
	assign pin_lvl = (aux_pin_oe & aux_pin_out) | (~aux_pin_oe & ext_lvl);
	// A released bus flips every cycle, so a stale byte can never pass for an answer.
	assign bus_lvl = slv_data_oe ? slv_data_out : (ext_drv ? ext_byte : ~last_bus);
	always @(posedge sys_clk) begin
		last_bus <= bus_lvl;
	end
	task automatic ext_write(input logic [7:0] b, input logic [2:0] lvl);
		@(posedge sys_clk);
		ext_byte <= b;
		ext_drv <= 1'b1;
		ext_lvl <= lvl;
		repeat (6) @(posedge sys_clk);
		ext_lvl <= 3'h7;
		@(posedge sys_clk);
		ext_drv <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic ext_read(output logic [7:0] b);
		@(posedge sys_clk);
		ext_lvl <= 3'h2;
		repeat (8) @(posedge sys_clk);
		b = bus_lvl;
		ext_lvl <= 3'h7;
		repeat (6) @(posedge sys_clk);
	endtask
endmodule // tpp_ext_cpu
`default_nettype wire

// *** test/tpp_port_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module tpp_port_properties (
	input wire logic       sys_clk,        // clock
	input wire logic       rst_b,          // reset, active low
	input wire logic       s_axi_awvalid,  // write address valid
	input wire logic       s_axi_awready,  // write address ready
	input wire logic       s_axi_wvalid,   // write data valid
	input wire logic       s_axi_wready,   // write data ready
	input wire logic       s_axi_bvalid,   // write response valid
	input wire logic       s_axi_arvalid,  // read address valid
	input wire logic       s_axi_arready,  // read address ready
	input wire logic       s_axi_rvalid,   // read data valid
	input wire logic [2:0] aux_pin_in,     // pin levels
	input wire logic [2:0] aux_pin_out,    // output latch
	input wire logic [2:0] aux_pin_oe,     // pin drive enables
	input wire logic [2:0] aux_analog_sel, // analog routing
	input wire logic [7:0] slv_data_out,   // outbound byte
	input wire logic       slv_data_oe     // bus drive enable
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	AST_RST_PINS: assert property ($rose(rst_b) |-> aux_analog_sel == 3'h7
		&& aux_pin_oe == 3'h0 && !slv_data_oe) else $error("pins not reset as analog inputs");
	AST_PSP_DRIVE: assert property ($rose(slv_data_oe) |->
		$past(aux_pin_in[0], 2) == 1'b0 && $past(aux_pin_in[2], 2) == 1'b0)
		else $error("bus driven without a selected read");
	AST_LATCH_SRC: assert property (!$stable(aux_pin_out) |-> $rose(s_axi_bvalid))
		else $error("latch changed without a write");
	AST_OUTBYTE_SRC: assert property (!$stable(slv_data_out) |-> $rose(s_axi_bvalid))
		else $error("outbound byte changed without a write");
	AST_DIR_DRIVE: assert property (!$stable(aux_pin_oe) |->
		$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)) else $error("drive enable moved alone");
	AST_ANA_SRC: assert property (!$stable(aux_analog_sel) |->
		$rose(s_axi_bvalid) || $past(s_axi_bvalid)) else $error("analog routing moved alone");
	AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready |=>
		!s_axi_arready ##1 s_axi_rvalid) else $error("read answer late");
	AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
endmodule // tpp_port_properties
bind tpp_port tpp_port_properties chk_u (
	.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .aux_pin_in(aux_pin_in), .aux_pin_out(aux_pin_out),
	.aux_pin_oe(aux_pin_oe), .aux_analog_sel(aux_analog_sel), .slv_data_out(slv_data_out),
	.slv_data_oe(slv_data_oe)
);
`default_nettype wire
